// file: src/madc_defs.svh
// Purpose: Register numbers, field positions, reset values and timing figures of the channel configuration block.
// Assumes: Register numbers are the decimal holding-register numbers written here in hexadecimal.
// Notes: Included by the design modules and the bench.
`ifndef MADC_DEFS_SVH
`define MADC_DEFS_SVH

`define MADC_REG_NODE 16'h9C41
`define MADC_REG_SETUP 16'h9C42
`define MADC_REG_DELAY 16'h9C43
`define MADC_REG_ENABLE 16'h9C44
`define MADC_REG_STATUS 16'h9C70
`define MADC_REG_DATA0 16'h9C71
`define MADC_REG_RANGE0 16'h9C81

`define MADC_RST_NODE 16'h0001
`define MADC_RST_SETUP 16'h0035
`define MADC_RST_DELAY 16'h0003
`define MADC_RST_ENABLE 16'h007F
`define MADC_RST_RANGE 3'h0
`define MADC_RST_DATA 16'h8000
`define MADC_RST_STATUS 16'h0000

`define MADC_NODE_MIN 16'h0001
`define MADC_NODE_MAX 16'h00DF
`define MADC_BAUD_LSB 0
`define MADC_BAUD_MSB 4
`define MADC_FRAME_LSB 5
`define MADC_FRAME_MSB 6
`define MADC_SETUP_USED 7
`define MADC_BAUD_MIN 5'h05
`define MADC_BAUD_MAX 5'h09
`define MADC_RESP_LSB 0
`define MADC_RESP_MSB 7
`define MADC_EOM_LSB 8
`define MADC_EOM_MSB 15
`define MADC_RESP_MAX 8'h3F
`define MADC_EOM_MAX 8'h30
`define MADC_RANGE_MAX 16'h0005
`define MADC_CNT_LSB 0
`define MADC_CNT_MSB 7
`define MADC_CHAN_LSB 8
`define MADC_CHAN_MSB 10

`define MADC_CLK_HZ 25000000
`define MADC_CONV_PER_S 25
`define MADC_TICK_MS 1
`define MADC_MS_CYCLES (`MADC_CLK_HZ / 1000 * `MADC_TICK_MS)
`define MADC_SLOT_CYCLES (`MADC_CLK_HZ / `MADC_CONV_PER_S)

`endif

// file: src/madc_pkg.sv
// Purpose: Types shared by the channel configuration block.
// Assumes: Constants live in madc_defs.svh.
// Notes: Requests arrive already decoded from the serial frame engine.
package madc_pkg;
  typedef struct packed {
    logic write;
    logic [7:0] node;
    logic [15:0] regnum;
    logic [15:0] wdata;
  } madc_req_t;

  typedef struct packed {
    logic err;
    logic [15:0] rdata;
  } madc_rsp_t;

  typedef enum logic [2:0] {
    MADC_R10V, MADC_R5V, MADC_R1V, MADC_R100MV, MADC_R50MV, MADC_R25MV
  } madc_range_t;

  typedef enum logic [1:0] {MADC_IDLE, MADC_EOMW, MADC_RESPW, MADC_TX} madc_state_t;
endpackage : madc_pkg

// file: src/madc_conv_seq.sv
// Purpose: Paces the shared converter and picks the next enabled channel.
// Assumes: One conversion slot per SLOT_CYCLES clocks.
// Notes: With no channel enabled the converter is simply left idle.
`timescale 1ns/10ps
`include "madc_defs.svh"
module madc_conv_seq #(
  parameter int NCH = 7,
  parameter int SLOT_CYCLES = `MADC_SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NCH-1:0] chan_en,
  output logic adc_start,
  output logic [2:0] adc_chan
);
  if (NCH < 1 || NCH > 8 || SLOT_CYCLES < 2) begin : g_chk
    $error("madc_conv_seq: unsupported parameters");
  end

  logic [$clog2(SLOT_CYCLES)-1:0] slot_cnt_ff;
  logic adc_start_ff;
  logic [2:0] adc_chan_ff;
  logic [NCH-1:0] en_d_ff;

  function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [NCH-1:0] en);
    logic [2:0] pick;
    logic found;
    int idx;
    pick = cur;
    found = 1'b0;
    for (int k = 1; k <= NCH; k++) begin
      idx = (int'(cur) + k) % NCH;
      if (!found && en[idx]) begin
        pick = 3'(idx);
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_chan

  wire slot_tick = (slot_cnt_ff == ($clog2(SLOT_CYCLES))'(SLOT_CYCLES - 1));
  wire [2:0] nxt_chan = next_chan(adc_chan_ff, chan_en);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slot_cnt_ff <= '0;
      adc_start_ff <= 1'b0;
      adc_chan_ff <= 3'(NCH - 1);
      en_d_ff <= '0;
    end else begin
      slot_cnt_ff <= slot_tick ? '0 : slot_cnt_ff + 1'b1;
      adc_start_ff <= slot_tick && (|chan_en);
      en_d_ff <= chan_en;
      if (slot_tick && (|chan_en)) begin
        adc_chan_ff <= nxt_chan;
      end
    end
  end

  assign adc_start = adc_start_ff;
  assign adc_chan = adc_chan_ff;

  slot_tick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    adc_start |-> $past(slot_tick) && !$past(adc_start)) else $error("start outside a slot tick");
  skip_chan_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    adc_start |-> en_d_ff[adc_chan]) else $error("disabled channel started");
endmodule : madc_conv_seq

// file: src/madc_cfg.sv
// Purpose: Holding registers, reply timing and conversion bookkeeping of the seven channel voltage module.
// Assumes: The frame engine hands over decoded requests and end-of-gap pulses on ref_clk.
// Notes: The converter returns two's complement samples; results are kept in offset binary.
// How it works
// - One shared converter delivers every result as a sixteen bit value.
// - Converter runs a fixed twenty-five conversions per second, shared among enabled channels.
// - Disabled channels are skipped so the enabled ones get more slots.
// - Each channel keeps its own range code, one of six bipolar ranges.
// - Registers are addressed by their decimal holding-register numbers from 40001.
// - Node address is read/write, accepts 1 through DF, resets to 0x0001.
// - Serial setup holds baud code in bits 0-4, framing in bits 5-6.
// - Serial setup resets to 0x0035, meaning 9600 baud, no parity, one stop.
// - Reply waits the low-byte response delay in milliseconds, at most 63, default 3.
// - End of message is extended by high-byte delay milliseconds, at most 48, default 0.
// - Status holds an 8-bit wrapping conversion count and last channel, zero after reset.
// - Channel results read as offset binary, zero input equals 0x8000.
`timescale 1ns/10ps
`include "madc_defs.svh"
module madc_cfg #(
  parameter int NCH = 7,
  parameter int MS_CYCLES = `MADC_MS_CYCLES,
  parameter int SLOT_CYCLES = `MADC_SLOT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire madc_pkg::madc_req_t req,
  input wire logic rx_gap,
  output logic eom,
  output logic rsp_valid,
  output madc_pkg::madc_rsp_t rsp,
  input wire logic tx_done,
  output logic drv_oe_n,
  output logic [4:0] baud_code,
  output logic [1:0] frame_mode,
  output logic adc_start,
  output logic [2:0] adc_chan,
  output logic [2:0] adc_range,
  input wire logic adc_done,
  input wire logic [15:0] adc_data
);
  if (NCH < 1 || NCH > 8 || MS_CYCLES < 2) begin : g_chk
    $error("madc_cfg: unsupported parameters");
  end

  localparam int PW = $clog2(MS_CYCLES);

  logic [15:0] node_ff;
  logic [15:0] setup_ff;
  logic [15:0] delay_ff;
  logic [NCH-1:0] en_ff;
  logic [15:0] status_ff;
  logic [2:0] range_ff [NCH];
  logic [15:0] data_ff [NCH];
  madc_pkg::madc_state_t state_ff;
  madc_pkg::madc_state_t nxt_state;
  logic [PW-1:0] ms_pre_ff;
  logic [7:0] ms_left_ff;
  logic [7:0] nxt_ms_left;
  madc_pkg::madc_rsp_t rsp_ff;

  // Register decode by holding-register number.
  wire [15:0] data_off = req.regnum - `MADC_REG_DATA0;
  wire [15:0] range_off = req.regnum - `MADC_REG_RANGE0;
  wire is_node = (req.regnum == `MADC_REG_NODE);
  wire is_setup = (req.regnum == `MADC_REG_SETUP);
  wire is_delay = (req.regnum == `MADC_REG_DELAY);
  wire is_enable = (req.regnum == `MADC_REG_ENABLE);
  wire is_status = (req.regnum == `MADC_REG_STATUS);
  wire is_data = (req.regnum >= `MADC_REG_DATA0) && (data_off < 16'(NCH));
  wire is_range = (req.regnum >= `MADC_REG_RANGE0) && (range_off < 16'(NCH));

  // Writes outside a field's legal values are refused whole.
  wire node_ok = (req.wdata >= `MADC_NODE_MIN) && (req.wdata <= `MADC_NODE_MAX);
  wire [4:0] wr_baud = req.wdata[`MADC_BAUD_MSB:`MADC_BAUD_LSB];
  wire setup_ok = (wr_baud >= `MADC_BAUD_MIN) && (wr_baud <= `MADC_BAUD_MAX)
    && ((req.wdata >> `MADC_SETUP_USED) == 16'h0000);
  wire delay_ok = (req.wdata[`MADC_RESP_MSB:`MADC_RESP_LSB] <= `MADC_RESP_MAX)
    && (req.wdata[`MADC_EOM_MSB:`MADC_EOM_LSB] <= `MADC_EOM_MAX);
  wire enable_ok = ((req.wdata >> NCH) == 16'h0000);
  wire range_ok = (req.wdata <= `MADC_RANGE_MAX);
  wire wr_ok = (is_node && node_ok) || (is_setup && setup_ok) || (is_delay && delay_ok)
    || (is_enable && enable_ok) || (is_range && range_ok);
  wire rd_ok = is_node || is_setup || is_delay || is_enable || is_status || is_data || is_range;

  // Frames for any other node, node zero included, are ignored whole so they cannot change our setup.
  wire addressed = (req.node == node_ff[7:0]);
  wire idle = (state_ff == madc_pkg::MADC_IDLE);
  wire take = req_valid && idle && !rx_gap && addressed;
  wire reply = take && addressed;
  wire wr_en = take && req.write && wr_ok;

  wire [15:0] rd_word = is_node ? node_ff :
    is_setup ? setup_ff :
    is_delay ? delay_ff :
    is_enable ? 16'(en_ff) :
    is_status ? status_ff :
    is_data ? data_ff[data_off[2:0]] :
    is_range ? 16'(range_ff[range_off[2:0]]) : 16'h0000;
  wire rsp_err = req.write ? !wr_ok : !rd_ok;
  wire [15:0] rsp_word = req.write ? req.wdata : rd_word;

  wire ms_tick = (ms_pre_ff == PW'(MS_CYCLES - 1));
  wire wait_over = (ms_left_ff == 8'h00);

  always_comb begin
    nxt_state = state_ff;
    nxt_ms_left = (ms_tick && !wait_over) ? ms_left_ff - 8'h01 : ms_left_ff;
    case (state_ff)
      madc_pkg::MADC_IDLE: begin
        if (rx_gap) begin
          nxt_state = madc_pkg::MADC_EOMW;
          nxt_ms_left = delay_ff[`MADC_EOM_MSB:`MADC_EOM_LSB];
        end else if (reply) begin
          nxt_state = madc_pkg::MADC_RESPW;
          nxt_ms_left = delay_ff[`MADC_RESP_MSB:`MADC_RESP_LSB];
        end
      end
      madc_pkg::MADC_EOMW: if (wait_over) nxt_state = madc_pkg::MADC_IDLE;
      madc_pkg::MADC_RESPW: if (wait_over) nxt_state = madc_pkg::MADC_TX;
      madc_pkg::MADC_TX: if (tx_done) nxt_state = madc_pkg::MADC_IDLE;
      default: nxt_state = madc_pkg::MADC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= madc_pkg::MADC_IDLE;
      ms_pre_ff <= '0;
      ms_left_ff <= 8'h00;
      rsp_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ms_pre_ff <= (idle || ms_tick) ? '0 : ms_pre_ff + 1'b1;
      ms_left_ff <= nxt_ms_left;
      if (reply) begin
        rsp_ff <= '{err: rsp_err, rdata: rsp_word};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      node_ff <= `MADC_RST_NODE;
      setup_ff <= `MADC_RST_SETUP;
      delay_ff <= `MADC_RST_DELAY;
      en_ff <= NCH'(`MADC_RST_ENABLE);
      status_ff <= `MADC_RST_STATUS;
    end else begin
      if (wr_en && is_node) node_ff <= req.wdata;
      if (wr_en && is_setup) setup_ff <= req.wdata;
      if (wr_en && is_delay) delay_ff <= req.wdata;
      if (wr_en && is_enable) en_ff <= req.wdata[NCH-1:0];
      if (adc_done) begin
        status_ff[`MADC_CNT_MSB:`MADC_CNT_LSB] <= status_ff[`MADC_CNT_MSB:`MADC_CNT_LSB] + 8'h01;
        status_ff[`MADC_CHAN_MSB:`MADC_CHAN_LSB] <= adc_chan;
      end
    end
  end

  // Per-channel range and result storage.
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        range_ff[c] <= `MADC_RST_RANGE;
        data_ff[c] <= `MADC_RST_DATA;
      end else begin
        if (wr_en && is_range && (range_off[2:0] == 3'(c))) range_ff[c] <= req.wdata[2:0];
        // Flipping the sign bit turns a two's complement sample into offset binary.
        if (adc_done && (adc_chan == 3'(c))) data_ff[c] <= {~adc_data[15], adc_data[14:0]};
      end
    end
  end

  madc_conv_seq #(
    .NCH(NCH),
    .SLOT_CYCLES(SLOT_CYCLES)
  ) u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .chan_en(en_ff),
    .adc_start(adc_start),
    .adc_chan(adc_chan)
  );

  assign adc_range = range_ff[adc_chan];
  assign eom = (state_ff == madc_pkg::MADC_EOMW) && wait_over;
  assign rsp_valid = (state_ff == madc_pkg::MADC_RESPW) && wait_over;
  assign rsp = rsp_ff;
  // The driver is only released once the reply delay has passed, so a slow host adapter can turn round.
  assign drv_oe_n = (state_ff != madc_pkg::MADC_TX);
  assign baud_code = setup_ff[`MADC_BAUD_MSB:`MADC_BAUD_LSB];
  assign frame_mode = setup_ff[`MADC_FRAME_MSB:`MADC_FRAME_LSB];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_fast_reply;
    reply && (delay_ff[`MADC_RESP_MSB:`MADC_RESP_LSB] == 8'h00);
  endsequence
  sequence s_foreign_req;
    req_valid && idle && !rx_gap && !addressed;
  endsequence
  sequence s_tx_end;
    tx_done && (state_ff == madc_pkg::MADC_TX);
  endsequence

  node_range_a: assert property ((node_ff >= `MADC_NODE_MIN) && (node_ff <= `MADC_NODE_MAX))
    else $error("node address out of range");
  setup_guard_a: assert property (take && req.write && is_setup && !setup_ok |=> $stable(setup_ff))
    else $error("bad setup write stored");
  reset_vals_a: assert property (disable iff (1'b0) !rst_n |=> (setup_ff == `MADC_RST_SETUP)
    && (node_ff == `MADC_RST_NODE) && (status_ff == `MADC_RST_STATUS)) else $error("reset values wrong");
  fast_reply_a: assert property (s_fast_reply |=> rsp_valid ##1 !drv_oe_n)
    else $error("zero delay reply late");
  eom_fast_a: assert property (idle && rx_gap && (delay_ff[`MADC_EOM_MSB:`MADC_EOM_LSB] == 8'h00) |=> eom)
    else $error("end of message not flagged");
  conv_count_a: assert property (adc_done |=> status_ff[7:0] == $past(status_ff[7:0]) + 8'h01)
    else $error("conversion count did not advance");
  offset_bin_a: assert property (adc_done |=> data_ff[$past(adc_chan)]
    == {~$past(adc_data[15]), $past(adc_data[14:0])}) else $error("result not offset binary");
  quiet_line_a: assert property (s_foreign_req |=> (idle && drv_oe_n) ##1 drv_oe_n [*2])
    else $error("driver on for a foreign frame");
  drv_release_a: assert property (s_tx_end |=> drv_oe_n && idle)
    else $error("driver held after reply");
  delay_guard_a: assert property (take && req.write && is_delay && !delay_ok |=> $stable(delay_ff))
    else $error("bad delay write stored");
  node_guard_a: assert property (take && req.write && is_node && !node_ok |=> $stable(node_ff))
    else $error("bad node write stored");
endmodule : madc_cfg

// file: verification/madc_host.sv
// Purpose: Host master model issuing one decoded request per idle period.
// Assumes: The reply is fully sent before the next request is made.
// Notes: Released request lines carry inverted data so stale values never match.
`timescale 1ns/10ps
module madc_host (
  input wire logic ref_clk,
  output logic req_valid,
  output madc_pkg::madc_req_t req,
  output logic tx_done,
  input wire logic rsp_valid,
  input wire madc_pkg::madc_rsp_t rsp,
  input wire logic drv_oe_n
);
  initial begin
    req_valid = 1'h0;
    req = '0;
    tx_done = 1'h0;
  end
  // Registers are named by their holding numbers from 40001, written in hex.
  task automatic send(input logic w, input logic [7:0] nd, input logic [15:0] rn, input logic [15:0] wd,
      output logic got, output madc_pkg::madc_rsp_t r, output int lat, output logic drove);
    got = 1'h0;
    drove = 1'h0;
    lat = 0;
    @(posedge ref_clk);
    req_valid <= 1'h1;
    req <= {w, nd, rn, wd};
    @(posedge ref_clk);
    req_valid <= 1'h0;
    req <= ~req;
    while (!got && lat < 300) begin
      @(negedge ref_clk);
      lat++;
      got = (rsp_valid === 1'h1);
      drove = drove | (drv_oe_n !== 1'h1);
    end
    r = rsp;
    // A slow host: the reply takes a few cycles to leave the line.
    if (got) begin
      repeat (3) @(posedge ref_clk);
      tx_done <= 1'h1;
      @(posedge ref_clk);
      tx_done <= 1'h0;
      @(negedge ref_clk);
    end
  endtask : send
endmodule : madc_host

// file: verification/test_madc_cfg.sv
// Purpose: Self-checking bench for the channel configuration block.
// Assumes: Short millisecond and slot counts keep the run brief.
// Notes: The bench plays the converter; the host model plays the master.
`timescale 1ns/10ps
`include "madc_defs.svh"
module test_madc_cfg;
  localparam int MS = 4;
  localparam int SLOT = 20;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic rx_gap = 1'h0;
  logic adc_done = 1'h0;
  logic pend = 1'h0;
  logic chk_on = 1'h0;
  logic [15:0] adc_data = 16'h0000;
  logic req_valid, tx_done, eom, rsp_valid, drv_oe_n, adc_start, got, drove;
  madc_pkg::madc_req_t req;
  madc_pkg::madc_rsp_t rsp, r;
  logic [4:0] baud_code;
  logic [1:0] frame_mode;
  logic [2:0] adc_chan, adc_range;
  logic [2:0] lastc = 3'h6;
  logic [2:0] ldone = 3'h0;
  logic [2:0] rng [7];
  logic [6:0] en = 7'h7F;
  logic [7:0] node_id = 8'h01;
  logic [7:0] ndone = 8'h00;
  int fails = 0;
  int check_count = 0;
  int lat, cyc, t_last;
  always #20 ref_clk = ~ref_clk;
  madc_cfg #(.NCH(7), .MS_CYCLES(MS), .SLOT_CYCLES(SLOT)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .rx_gap(rx_gap), .eom(eom), .rsp_valid(rsp_valid), .rsp(rsp),
    .tx_done(tx_done), .drv_oe_n(drv_oe_n), .baud_code(baud_code), .frame_mode(frame_mode),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_range(adc_range), .adc_done(adc_done),
    .adc_data(adc_data));
  madc_host u_host (.ref_clk(ref_clk), .req_valid(req_valid), .req(req), .tx_done(tx_done),
    .rsp_valid(rsp_valid), .rsp(rsp), .drv_oe_n(drv_oe_n));
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  function automatic logic [15:0] win(input int n, input int d);
    return {15'h0, n >= 1 + MS * d && n <= 2 + MS * d};
  endfunction : win
  function automatic logic [2:0] nxt(input logic [2:0] c);
    logic [2:0] k;
    k = c;
    for (int i = 0; i < 7; i++) begin
      k = (k == 3'h6) ? 3'h0 : k + 3'h1;
      if (en[k]) return k;
    end
    return k;
  endfunction : nxt
  // The converter answers one cycle after each start; data lines toggle when idle.
  always @(negedge ref_clk) begin
    cyc++;
    pend = rst_n && adc_start === 1'h1;
    if (pend) begin
      if (chk_on) begin
        cmp("slot", 16'(SLOT), 16'(cyc - t_last));
        cmp("chan", {13'h0, nxt(lastc)}, {13'h0, adc_chan});
        cmp("range", {13'h0, rng[adc_chan]}, {13'h0, adc_range});
      end
      t_last = cyc;
      lastc = adc_chan;
    end
  end
  always @(posedge ref_clk) begin
    adc_done <= pend;
    adc_data <= pend ? {lastc, 13'h0000} : ~adc_data;
    if (pend) begin
      ndone <= ndone + 8'h01;
      ldone <= lastc;
    end
  end
  task automatic rd(input logic [15:0] rn, input logic [15:0] e);
    u_host.send(1'h0, node_id, rn, 16'h0000, got, r, lat, drove);
    cmp("reply", 16'h0001, {15'h0, got & ~drove});
    cmp("err", 16'h0000, {15'h0, r.err});
    cmp("rdata", e, r.rdata);
  endtask : rd
  task automatic wr(input logic [15:0] rn, input logic [15:0] v, input logic ee);
    u_host.send(1'h1, node_id, rn, v, got, r, lat, drove);
    cmp("reply", 16'h0001, {15'h0, got & ~drove});
    cmp("err", {15'h0, ee}, {15'h0, r.err});
    cmp("echo", v, r.rdata);
  endtask : wr
  task automatic t_gap(input int e);
    int n;
    n = 0;
    @(posedge ref_clk);
    rx_gap <= 1'h1;
    @(posedge ref_clk);
    rx_gap <= 1'h0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (eom !== 1'h1 && n < 300);
    cmp("eom", 16'h0001, win(n, e));
  endtask : t_gap
  task automatic t_reset;
    cmp("frame", 16'h0001, {14'h0, frame_mode});
    cmp("baud", 16'h0015, {11'h0, baud_code});
    rd(`MADC_REG_STATUS, {5'h0, ldone, ndone});
    cmp("lat", 16'h0001, win(lat, 3));
    rd(`MADC_REG_NODE, 16'h0001);
    rd(`MADC_REG_SETUP, 16'h0035);
    rd(`MADC_REG_DELAY, 16'h0003);
    rd(`MADC_REG_ENABLE, 16'h007F);
    u_host.send(1'h0, node_id, 16'h9C40, 16'h0000, got, r, lat, drove);
    cmp("unmapped", 16'h0001, {15'h0, r.err});
  endtask : t_reset
  task automatic t_setup;
    logic [15:0] v;
    for (int b = 5; b <= 9; b++) begin
      v = {9'h0, 2'(b % 4), 5'(b)};
      wr(`MADC_REG_SETUP, v, 1'h0);
      cmp("baud", 16'(b), {11'h0, baud_code});
      cmp("frame", 16'(b % 4), {14'h0, frame_mode});
    end
    wr(`MADC_REG_SETUP, 16'h0004, 1'h1);
    wr(`MADC_REG_SETUP, 16'h000A, 1'h1);
    rd(`MADC_REG_SETUP, v);
  endtask : t_setup
  task automatic t_node;
    wr(`MADC_REG_NODE, 16'h00DF, 1'h0);
    node_id = 8'hDF;
    u_host.send(1'h0, 8'h01, `MADC_REG_NODE, 16'h0000, got, r, lat, drove);
    cmp("foreign", 16'h0000, {14'h0, got, drove});
    u_host.send(1'h1, 8'h00, `MADC_REG_DELAY, 16'h0000, got, r, lat, drove);
    cmp("bcast", 16'h0000, {14'h0, got, drove});
    rd(`MADC_REG_DELAY, 16'h0003);
    rd(`MADC_REG_NODE, 16'h00DF);
    wr(`MADC_REG_NODE, 16'h00E0, 1'h1);
    wr(`MADC_REG_NODE, 16'h0000, 1'h1);
    wr(`MADC_REG_NODE, 16'h0001, 1'h0);
    node_id = 8'h01;
  endtask : t_node
  task automatic t_delay;
    wr(`MADC_REG_DELAY, 16'h0040, 1'h1);
    wr(`MADC_REG_DELAY, 16'h3100, 1'h1);
    wr(`MADC_REG_DELAY, 16'h303F, 1'h0);
    rd(`MADC_REG_DELAY, 16'h303F);
    cmp("lat", 16'h0001, win(lat, 63));
    t_gap(48);
    wr(`MADC_REG_DELAY, 16'h0000, 1'h0);
    t_gap(0);
  endtask : t_delay
  task automatic t_range;
    for (int c = 0; c < 7; c++) begin
      rng[c] = 3'(c % 6);
      wr(`MADC_REG_RANGE0 + 16'(c), {13'h0, rng[c]}, 1'h0);
      rd(`MADC_REG_RANGE0 + 16'(c), {13'h0, rng[c]});
    end
    wr(`MADC_REG_RANGE0, 16'h0006, 1'h1);
  endtask : t_range
  task automatic t_conv;
    en = 7'h45;
    wr(`MADC_REG_ENABLE, 16'h0045, 1'h0);
    repeat (SLOT + 2) @(posedge ref_clk);
    chk_on = 1'h1;
    repeat (7 * SLOT) @(posedge ref_clk);
    chk_on = 1'h0;
    wr(`MADC_REG_ENABLE, 16'h0000, 1'h0);
    repeat (SLOT) @(posedge ref_clk);
    rd(`MADC_REG_STATUS, {5'h0, ldone, ndone});
    rd(`MADC_REG_DATA0, 16'h8000);
    rd(`MADC_REG_DATA0 + 16'h0002, 16'hC000);
    rd(`MADC_REG_DATA0 + 16'h0006, 16'h4000);
    wr(`MADC_REG_STATUS, 16'h0000, 1'h1);
  endtask : t_conv
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset;
    t_setup;
    t_node;
    t_delay;
    t_range;
    t_conv;
    conclude;
  end
endmodule : test_madc_cfg
